// ==== rtl/icd_pkg.sv ====
// package for the interrupt command decoder: bus map, command patterns,
// mode fields, state encodings and bus carrier structs.
// assumes a 32-bit APB master with word aligned byte addresses.
package icd_pkg;
	// ==================================================================
	// register map (byte addresses)
	localparam int unsigned ADDR_W = 8;
	localparam logic [7:0] OFS_B_CMD  = 8'h00; // port b control/status, command
	localparam logic [7:0] OFS_B_DATA = 8'h04; // port b data port
	localparam logic [7:0] OFS_D_CMD  = 8'h08; // port d control/status, command
	localparam logic [7:0] OFS_D_DATA = 8'h0C; // port d data port
	localparam logic [7:0] OFS_PEND   = 8'h10;
	localparam logic [7:0] OFS_MASK   = 8'h14;
	localparam logic [7:0] OFS_INSV   = 8'h18;
	localparam logic [7:0] OFS_MODE   = 8'h1C;
	localparam logic [7:0] OFS_ACR    = 8'h20;
	localparam logic [7:0] OFS_VACK   = 8'h24; // acknowledge: pops one vector byte
	localparam logic [7:0] OFS_ISTS   = 8'h28; // sticky events, write one to clear
	localparam logic [7:0] OFS_IMSK   = 8'h2C;
	// ==================================================================
	// command patterns
	localparam logic [7:0] CMD_REQ_CLR1 = 8'b01001???;
	localparam logic [7:0] CMD_REQ_SETA = 8'b01010???;
	localparam logic [7:0] CMD_REQ_SET1 = 8'b01011???;
	localparam logic [7:0] CMD_ISV_TOP  = 8'b0110????;
	localparam logic [7:0] CMD_ISV_CLRA = 8'b01110???;
	localparam logic [7:0] CMD_ISV_CLR1 = 8'b01111???;
	localparam logic [7:0] CMD_MODE_LO  = 8'b100?????;
	localparam logic [7:0] CMD_MODE_HI  = 8'b1010????;
	localparam logic [7:0] CMD_SEL_MASK = 8'b1011????;
	localparam logic [7:0] CMD_SEL_ACR  = 8'b1100????;
	localparam logic [7:0] CMD_SEL_VEC  = 8'b111?????;
	// ==================================================================
	// field positions
	localparam int unsigned BSEL_LSB = 0; // bit_select_field / vector_level_field
	localparam int unsigned BSEL_W   = 3;
	localparam int unsigned BCNT_LSB = 3; // vector_byte_count_field
	localparam int unsigned MLOW_LSB = 0; // mode_low_field
	localparam int unsigned MLOW_W   = 5;
	localparam int unsigned PSEL_LSB = 5; // register_preselect_mode_bits in mode
	localparam int unsigned PCMD_LSB = 2; // same bits inside the command
	localparam int unsigned MMSK_BIT = 7; // master_mask_bit
	localparam logic [1:0] MMC_KEEP = 2'h0; // master_mask_control_field
	localparam logic [1:0] MMC_SET  = 2'h1;
	localparam logic [1:0] MMC_CLR  = 2'h2;
	localparam int unsigned EV_REQ = 0; // event: new request latched
	localparam int unsigned EV_BAD = 1; // event: illegal master mask code
	localparam int unsigned EV_W   = 2;
	// ==================================================================
	// types
	typedef enum logic [1:0] {TGT_NONE, TGT_MASK, TGT_ACR, TGT_VEC} icd_tgt_e;
	typedef enum logic [3:0] {OP_NONE, OP_REQ_CLR1, OP_REQ_SETA, OP_REQ_SET1, OP_ISV_TOP,
		OP_ISV_CLRA, OP_ISV_CLR1, OP_MODE_LO, OP_MODE_HI, OP_SEL_MASK, OP_SEL_ACR,
		OP_SEL_VEC} icd_op_e;
	typedef struct packed {
		logic              psel;
		logic              penable;
		logic              pwrite;
		logic [ADDR_W-1:0] paddr;
		logic [31:0]       pwdata;
	} icd_apb_req_s;
	typedef struct packed {
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
	} icd_apb_rsp_s;
endpackage

// ==== rtl/icd_top.sv ====
// interrupt command decoder with request sources, vector memory and APB slave.
// assumes request pins and the jumper are asynchronous; bus on clk_sys.
//
// Local design decisions: the placing of the registers and the APB register port.
`timescale 1ns/100ps
`default_nettype none
module icd_top
	import icd_pkg::*;
(
	// clock and reset
	input  wire logic                 clk_sys,
	input  wire logic                 srst,
	// register bus
	input  wire icd_pkg::icd_apb_req_s apb_req,
	output icd_pkg::icd_apb_rsp_s     apb_rsp,
	// request pins
	input  wire logic [7:0]           port_a_high,
	input  wire logic [3:0]           user_reply_inputs,
	input  wire logic                 request_source_jumper,
	// interrupt outputs
	output logic                      vector_int_req,
	output logic                      irq
);
	import icd_pkg::*;

	// ==================================================================
	// state
	typedef struct packed {
		logic [7:0]            pend;
		logic [7:0]            mask;
		logic [7:0]            insv;
		logic [7:0]            mode;
		logic [7:0]            auxiliary_control_reg;
		icd_tgt_e              tgt;
		logic [2:0]            vlev;
		logic [7:0][1:0]       cnt;
		logic [7:0][1:0]       wptr;
		logic [1:0]            rptr;
		logic [7:0][3:0][7:0]  vmem;
		logic [12:0]           s1;
		logic [12:0]           s2;
		logic [7:0]            src_d;
		logic [EV_W-1:0]       ists;
		logic [EV_W-1:0]       imsk;
		logic                  rdy;
		logic                  err;
		logic [31:0]           rdat;
	} icd_state_s;

	icd_state_s st_reg;
	icd_state_s st_next;

	// lowest index set bit wins priority
	function automatic logic [7:0] icd_lowest(input logic [7:0] v);
		return v & (~v + 8'h01);
	endfunction

	function automatic logic [2:0] icd_index(input logic [7:0] oh);
		logic [2:0] r;
		r = '0;
		for (int i = 0; i < 8; i++) begin
			if (oh[i]) begin
				r = 3'(i);
			end
		end
		return r;
	endfunction

	function automatic logic icd_mapped(input logic [ADDR_W-1:0] a);
		return a inside {OFS_B_CMD, OFS_B_DATA, OFS_D_CMD, OFS_D_DATA, OFS_PEND, OFS_MASK,
			OFS_INSV, OFS_MODE, OFS_ACR, OFS_VACK, OFS_ISTS, OFS_IMSK};
	endfunction

	logic       access;
	logic       fire;
	logic       cmd_fire;
	logic       dat_fire;
	logic [7:0] cmd;
	logic [2:0] bsel;
	logic [7:0] src;
	logic [7:0] req_edge;
	logic [7:0] live;
	logic [2:0] ack_lev;
	icd_op_e    op;

	// ==================================================================
	// bus qualifiers and command decode
	always_comb begin
		access   = apb_req.psel && apb_req.penable;
		fire     = access && st_reg.rdy;
		cmd_fire = fire && apb_req.pwrite
			&& (apb_req.paddr == OFS_B_CMD || apb_req.paddr == OFS_D_CMD);
		dat_fire = fire && apb_req.pwrite
			&& (apb_req.paddr == OFS_B_DATA || apb_req.paddr == OFS_D_DATA);
		cmd      = apb_req.pwdata[7:0];
		bsel     = cmd[BSEL_LSB +: BSEL_W];
		casez (cmd)
			CMD_REQ_CLR1: op = OP_REQ_CLR1;
			CMD_REQ_SETA: op = OP_REQ_SETA;
			CMD_REQ_SET1: op = OP_REQ_SET1;
			CMD_ISV_TOP:  op = OP_ISV_TOP;
			CMD_ISV_CLRA: op = OP_ISV_CLRA;
			CMD_ISV_CLR1: op = OP_ISV_CLR1;
			CMD_MODE_LO:  op = OP_MODE_LO;
			CMD_MODE_HI:  op = OP_MODE_HI;
			CMD_SEL_MASK: op = OP_SEL_MASK;
			CMD_SEL_ACR:  op = OP_SEL_ACR;
			CMD_SEL_VEC:  op = OP_SEL_VEC;
			default:      op = OP_NONE; // other codes only end a preselect
		endcase
		// source select; jumper sampled after its synchroniser
		src = st_reg.s2[12] ? {st_reg.s2[11:8], st_reg.s2[3:0]} : st_reg.s2[7:0];
		req_edge = src & ~st_reg.src_d;
		live     = icd_lowest(st_reg.pend & ~st_reg.mask);
		ack_lev  = icd_index(live);
	end

	// ==================================================================
	// next state
	always_comb begin
		st_next = st_reg;
		// two-stage synchroniser; stage one feeds stage two only
		st_next.s1    = {request_source_jumper, user_reply_inputs, port_a_high};
		st_next.s2    = st_reg.s1;
		st_next.src_d = src;
		// zero-wait not used: one cycle to register read data, then ready
		st_next.rdy = access && !st_reg.rdy;
		if (access && !st_reg.rdy) begin
			st_next.err = !icd_mapped(apb_req.paddr);
			unique case (apb_req.paddr)
				OFS_PEND: st_next.rdat = {24'h0, st_reg.pend};
				OFS_MASK: st_next.rdat = {24'h0, st_reg.mask};
				OFS_INSV: st_next.rdat = {24'h0, st_reg.insv};
				OFS_MODE: st_next.rdat = {24'h0, st_reg.mode};
				OFS_ACR:  st_next.rdat = {24'h0, st_reg.auxiliary_control_reg};
				OFS_VACK: st_next.rdat = (|live) ? {24'h0, st_reg.vmem[ack_lev][st_reg.rptr]}
					: 32'h0;
				OFS_ISTS: st_next.rdat = {30'h0, st_reg.ists};
				OFS_IMSK: st_next.rdat = {30'h0, st_reg.imsk};
				default:  st_next.rdat = 32'h0;
			endcase
		end
		// commands
		if (cmd_fire) begin
			unique case (op)
				OP_REQ_CLR1: st_next.pend[bsel] = 1'b0;
				OP_REQ_SETA: st_next.pend = 8'hFF;
				OP_REQ_SET1: st_next.pend[bsel] = 1'b1;
				OP_ISV_TOP:  st_next.insv = st_reg.insv & ~icd_lowest(st_reg.insv);
				OP_ISV_CLRA: st_next.insv = 8'h00;
				OP_ISV_CLR1: st_next.insv[bsel] = 1'b0;
				OP_MODE_LO:  st_next.mode[MLOW_LSB +: MLOW_W] = cmd[MLOW_LSB +: MLOW_W];
				OP_MODE_HI: begin
					st_next.mode[PSEL_LSB +: 2] = cmd[PCMD_LSB +: 2];
					if (cmd[1:0] == MMC_SET) begin
						st_next.mode[MMSK_BIT] = 1'b1;
					end else if (cmd[1:0] == MMC_CLR) begin
						st_next.mode[MMSK_BIT] = 1'b0;
					end
				end
				OP_SEL_MASK: st_next.tgt = TGT_MASK;
				OP_SEL_ACR:  st_next.tgt = TGT_ACR;
				OP_SEL_VEC: begin
					st_next.tgt       = TGT_VEC;
					st_next.vlev      = bsel;
					st_next.cnt[bsel] = cmd[BCNT_LSB +: 2];
					st_next.wptr[bsel] = 2'h0;
					st_next.rptr      = 2'h0;
				end
				default: st_next.tgt = st_reg.tgt;
			endcase
			// any other command ends a preselect; only OP_MODE_LO and OP_MODE_HI change mode
			if (!(op inside {OP_SEL_MASK, OP_SEL_ACR, OP_SEL_VEC})) begin
				st_next.tgt = TGT_NONE;
			end
		end
		// data port writes go to the preselected target until the next command
		if (dat_fire) begin
			unique case (st_reg.tgt)
				TGT_MASK: st_next.mask = apb_req.pwdata[7:0];
				TGT_ACR:  st_next.auxiliary_control_reg = apb_req.pwdata[7:0];
				TGT_VEC: begin
					st_next.vmem[st_reg.vlev][st_reg.wptr[st_reg.vlev]] = apb_req.pwdata[7:0];
					if (st_reg.wptr[st_reg.vlev] != 2'h3) begin
						st_next.wptr[st_reg.vlev] = st_reg.wptr[st_reg.vlev] + 2'h1;
					end
				end
				TGT_NONE: st_next.tgt = TGT_NONE;
			endcase
		end
		// acknowledge read: level stays pending until its last byte is taken
		if (fire && !apb_req.pwrite && apb_req.paddr == OFS_VACK && |live) begin
			if (st_reg.rptr == st_reg.cnt[ack_lev]) begin
				st_next.rptr          = 2'h0;
				st_next.pend[ack_lev] = 1'b0;
				st_next.insv[ack_lev] = 1'b1;
			end else begin
				st_next.rptr = st_reg.rptr + 2'h1;
			end
		end
		// interrupt event bits: write one clears, a new event in the same cycle wins
		if (fire && apb_req.pwrite && apb_req.paddr == OFS_ISTS) begin
			st_next.ists = st_reg.ists & ~apb_req.pwdata[EV_W-1:0];
		end
		if (fire && apb_req.pwrite && apb_req.paddr == OFS_IMSK) begin
			st_next.imsk = apb_req.pwdata[EV_W-1:0];
		end
		st_next.ists[EV_BAD] = st_next.ists[EV_BAD] | (cmd_fire && op == OP_MODE_HI
			&& cmd[1:0] == (MMC_SET | MMC_CLR));
		st_next.ists[EV_REQ] = st_next.ists[EV_REQ] | (|req_edge);
		// request edges are applied last so they win over a clear
		st_next.pend = st_next.pend | req_edge;
	end

	// ==================================================================
	// registers
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	// ==================================================================
	// outputs
	always_comb begin
		apb_rsp.prdata  = st_reg.rdat;
		apb_rsp.pready  = st_reg.rdy;
		apb_rsp.pslverr = st_reg.rdy && st_reg.err;
		// master mask set holds off every vectored request
		vector_int_req  = (|live) && !st_reg.mode[MMSK_BIT];
		irq             = |(st_reg.ists & st_reg.imsk);
	end

	// ==================================================================
	// checks
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (srst);

	// request bit commands; a pin edge landing in the same cycle may beat a clear
	a_req_bit_clear: assert property (
		cmd_fire && op == OP_REQ_CLR1 && !req_edge[bsel]
		|=> !st_reg.pend[$past(bsel)])
		else $error("request bit not cleared");
	a_req_bit_set: assert property (
		cmd_fire && op == OP_REQ_SET1
		|=> st_reg.pend[$past(bsel)])
		else $error("request bit not set");
	a_req_set_all: assert property (
		cmd_fire && op == OP_REQ_SETA
		|=> &st_reg.pend)
		else $error("request bits not all set");
	a_req_edge_latch: assert property (
		|req_edge
		|=> (st_reg.pend & $past(req_edge)) == $past(req_edge) && st_reg.ists[EV_REQ])
		else $error("pin request edge not latched");

	// in-service commands; one transfer completes per cycle, so no ack overlaps
	a_isv_clr_top: assert property (
		cmd_fire && op == OP_ISV_TOP
		|=> st_reg.insv == ($past(st_reg.insv) & ~icd_lowest($past(st_reg.insv))))
		else $error("wrong in-service bit cleared");
	a_isv_bit_clear: assert property (
		cmd_fire && op == OP_ISV_CLR1
		|=> !st_reg.insv[$past(bsel)])
		else $error("in-service bit not cleared");
	a_isv_clr_all: assert property (
		cmd_fire && op == OP_ISV_CLRA
		|=> st_reg.insv == 8'h00)
		else $error("in-service bits remain");

	// mode loads; a set master mask must hold off the vectored request at once
	a_mode_low_load: assert property (
		cmd_fire && op == OP_MODE_LO
		|=> st_reg.mode[MLOW_LSB +: MLOW_W] == $past(cmd[MLOW_LSB +: MLOW_W]))
		else $error("mode low field not loaded");
	a_master_keep: assert property (
		cmd_fire && op == OP_MODE_HI && cmd[1:0] == MMC_KEEP
		|=> st_reg.mode[MMSK_BIT] == $past(st_reg.mode[MMSK_BIT])
		&& st_reg.mode[PSEL_LSB +: 2] == $past(cmd[PCMD_LSB +: 2]))
		else $error("master mask changed");
	a_master_set: assert property (
		cmd_fire && op == OP_MODE_HI && cmd[1:0] == MMC_SET
		|=> (st_reg.mode[MMSK_BIT] && !vector_int_req) [*2])
		else $error("master mask not set or output not held off");
	a_master_clr: assert property (
		cmd_fire && op == OP_MODE_HI && cmd[1:0] == MMC_CLR
		|=> !st_reg.mode[MMSK_BIT])
		else $error("master mask not cleared");

	// preselects and the data port
	a_mask_select: assert property (
		cmd_fire && op == OP_SEL_MASK
		|=> st_reg.tgt == TGT_MASK)
		else $error("mask not preselected");
	a_mask_target: assert property (
		dat_fire && st_reg.tgt == TGT_MASK
		|=> st_reg.mask == $past(apb_req.pwdata[7:0]))
		else $error("mask write lost");
	a_acr_select: assert property (
		cmd_fire && op == OP_SEL_ACR
		|=> st_reg.tgt == TGT_ACR)
		else $error("auxiliary control not preselected");
	a_acr_target: assert property (
		dat_fire && st_reg.tgt == TGT_ACR
		|=> st_reg.auxiliary_control_reg == $past(apb_req.pwdata[7:0]))
		else $error("auxiliary control write lost");
	a_vec_select: assert property (
		cmd_fire && op == OP_SEL_VEC
		|=> st_reg.tgt == TGT_VEC && st_reg.vlev == $past(bsel) && st_reg.rptr == 2'h0
		&& st_reg.cnt[$past(bsel)] == $past(cmd[BCNT_LSB +: 2]))
		else $error("vector level or byte count not stored");
	a_target_cancel: assert property (
		cmd_fire && !(op inside {OP_SEL_MASK, OP_SEL_ACR, OP_SEL_VEC})
		|=> st_reg.tgt == TGT_NONE)
		else $error("preselect not cancelled");
	a_target_hold: assert property (
		!cmd_fire
		|=> st_reg.tgt == $past(st_reg.tgt))
		else $error("preselect changed without a command");
	a_mode_untouched: assert property (
		cmd_fire && op inside {OP_SEL_MASK, OP_SEL_ACR}
		|=> $stable(st_reg.mode))
		else $error("preselect changed mode");

	// acknowledge reads walk the stored byte count of the level being served
	a_ack_byte_step: assert property (
		fire && !apb_req.pwrite && apb_req.paddr == OFS_VACK && |live
		&& st_reg.rptr != st_reg.cnt[ack_lev]
		|=> st_reg.rptr == $past(st_reg.rptr) + 2'h1)
		else $error("vector byte pointer did not step");
	a_ack_level_done: assert property (
		fire && !apb_req.pwrite && apb_req.paddr == OFS_VACK && |live
		&& st_reg.rptr == st_reg.cnt[ack_lev]
		|=> st_reg.rptr == 2'h0 && st_reg.insv[$past(ack_lev)])
		else $error("served level not moved to in-service");
endmodule
`default_nettype wire

// ==== tb/icd_host_model.sv ====
// host side model: a register bus master issuing command, data and read transfers.
// assumes one clock; the bench calls xfer hierarchically, one transfer at a time.
`timescale 1ns/100ps
`default_nettype none
module icd_host_model
	import icd_pkg::*;
(
	// clock
	input  wire logic                  clk_sys,
	// register bus
	output var icd_pkg::icd_apb_req_s  apb_req,
	input  wire icd_pkg::icd_apb_rsp_s apb_rsp
);
	// ==================================================================
	// bus cycles
	initial apb_req = '0;
	// one transfer; returns at the edge where the slave answered
	task automatic xfer(input logic wr, input logic [7:0] addr, input logic [7:0] data);
		logic [7:0] d;
		d = data;
		// master mask control 11 is never sent; keep code goes out instead
		if (wr && addr < 8'h10 && !addr[2] && d[7:4] == 4'hA && d[1:0] == 2'h3) d[1:0] = 2'h0;
		@(posedge clk_sys);
		apb_req.psel    <= 1'b1;
		apb_req.pwrite  <= wr;
		apb_req.paddr   <= addr;
		apb_req.pwdata  <= {24'h000000, d};
		@(posedge clk_sys);
		apb_req.penable <= 1'b1;
		// hold everything until pready is seen high
		do @(posedge clk_sys); while (apb_rsp.pready !== 1'b1);
		apb_req.psel    <= 1'b0;
		apb_req.penable <= 1'b0;
		apb_req.pwdata  <= ~apb_req.pwdata; // released data must not look valid
	endtask
endmodule
`default_nettype wire

// ==== tb/tb_top.sv ====
// testbench for the interrupt command decoder: commands, preselects, acks, pins.
// assumes pin edges reach the pending bits within a few cycles.
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, s) begin checked++; if ((e) !== (s)) begin errors++; \
	$display("CHECK FAILED %s expected %h seen %h", nm, e, s); end end
module tb_top;
	import icd_pkg::*;
	logic         clk_sys, srst, request_source_jumper, vector_int_req, irq;
	logic [7:0]   port_a_high, pend;
	logic [3:0]   user_reply_inputs;
	logic [2:0]   b;
	logic [40:0]  e;
	logic [40:0]  exp_q[$];
	logic [7:0]   ro[6] = '{OFS_PEND, OFS_MASK, OFS_INSV, OFS_MODE, OFS_ACR, OFS_ISTS};
	icd_apb_req_s apb_req;
	icd_apb_rsp_s apb_rsp;
	int           errors = 0, checked = 0, cyc = 0, seed = 32'haaf16e49;
	// ==================================================================
	// design and host
	icd_top dut (.clk_sys(clk_sys), .srst(srst), .apb_req(apb_req), .apb_rsp(apb_rsp),
		.port_a_high(port_a_high), .user_reply_inputs(user_reply_inputs),
		.request_source_jumper(request_source_jumper), .vector_int_req(vector_int_req),
		.irq(irq));
	icd_host_model host (.clk_sys(clk_sys), .apb_req(apb_req), .apb_rsp(apb_rsp));
	initial begin
		clk_sys = 1'b0;
		forever #10 clk_sys = ~clk_sys;
	end
	// ==================================================================
	// tasks
	task automatic summarize();
		$display("checks %0d errors %0d", checked, errors);
		if (errors == 0 && checked > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		host.xfer(1'b1, a, d);
	endtask
	task automatic cmd(input logic [7:0] c);
		wr(OFS_B_CMD, c);
	endtask
	// note the expected answer, then read; the monitor compares
	task automatic rd(input logic [7:0] a, input logic [7:0] d, input logic err);
		exp_q.push_back({a, err, 24'h000000, d});
		host.xfer(1'b0, a, 8'h00);
	endtask
	// level outputs, looked at once the last write has landed
	task automatic outs(input logic xi, input logic xv);
		repeat (2) @(posedge clk_sys);
		#1;
		`CHK("irq", xi, irq)
		`CHK("vector_int_req", xv, vector_int_req)
	endtask
	task automatic pins(input logic [7:0] pa, input logic [3:0] ur);
		@(posedge clk_sys);
		port_a_high       <= pa;
		user_reply_inputs <= ur;
		repeat (6) @(posedge clk_sys);
	endtask
	// ==================================================================
	// read monitor: oldest note against each answer
	always @(posedge clk_sys) begin
		if (apb_req.psel && apb_req.penable && !apb_req.pwrite && apb_rsp.pready === 1'b1) begin
			if (exp_q.size() == 0) begin
				errors++;
				$display("CHECK FAILED read_queue expected note seen none");
			end else begin
				e = exp_q.pop_front();
				`CHK($sformatf("reg_%h", e[40:33]), e[32:0], {apb_rsp.pslverr, apb_rsp.prdata})
			end
		end
	end
	// hang guard
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 20000) begin
			errors++;
			summarize();
		end
	end
	// ==================================================================
	// main sequence
	initial begin
		srst = 1'b1;
		request_source_jumper = 1'b1;
		port_a_high = 8'h00;
		user_reply_inputs = 4'h0;
		repeat (2) @(posedge clk_sys);
		srst <= 1'b0;
		@(posedge clk_sys);
		foreach (ro[i]) rd(ro[i], 8'h00, 1'b0);
		rd(8'h30, 8'h00, 1'b1); // unmapped
		cmd(8'h50);
		pend = 8'hFF;
		rd(OFS_PEND, pend, 1'b0);
		// random single bit set and clear
		for (int k = 0; k < 12; k++) begin
			b = 3'($random(seed));
			if ($random(seed) & 1) begin
				cmd({5'b01011, b});
				pend[b] = 1'b1;
			end else begin
				cmd({5'b01001, b});
				pend[b] = 1'b0;
			end
			rd(OFS_PEND, pend, 1'b0);
		end
		cmd(8'h50);
		cmd(8'h95);
		rd(OFS_MODE, 8'h15, 1'b0);
		cmd(8'hAD);
		rd(OFS_MODE, 8'hF5, 1'b0);
		outs(1'b0, 1'b0);
		cmd(8'hA8);
		rd(OFS_MODE, 8'hD5, 1'b0);
		cmd(8'hA2);
		rd(OFS_MODE, 8'h15, 1'b0);
		outs(1'b0, 1'b1);
		// preselects with reads in between
		cmd(8'hB0);
		rd(OFS_MODE, 8'h15, 1'b0);
		wr(OFS_B_DATA, 8'h5A);
		rd(OFS_MASK, 8'h5A, 1'b0);
		wr(OFS_D_DATA, 8'hF8);
		rd(OFS_MASK, 8'hF8, 1'b0);
		wr(OFS_D_CMD, 8'hC0);
		wr(OFS_D_DATA, 8'h3C);
		rd(OFS_ACR, 8'h3C, 1'b0);
		rd(OFS_MASK, 8'hF8, 1'b0);
		// vectors: level 1 one byte, level 2 two bytes
		cmd(8'hE1);
		wr(OFS_B_DATA, 8'h77);
		cmd(8'hEA);
		wr(OFS_B_DATA, 8'h11);
		wr(OFS_B_DATA, 8'h22);
		rd(OFS_VACK, 8'h00, 1'b0);
		rd(OFS_VACK, 8'h77, 1'b0);
		rd(OFS_VACK, 8'h11, 1'b0);
		rd(OFS_VACK, 8'h22, 1'b0);
		rd(OFS_INSV, 8'h07, 1'b0);
		rd(OFS_PEND, 8'hF8, 1'b0);
		cmd(8'h7A);
		rd(OFS_INSV, 8'h03, 1'b0);
		cmd(8'h60);
		rd(OFS_INSV, 8'h02, 1'b0);
		cmd(8'h70);
		rd(OFS_INSV, 8'h00, 1'b0);
		// pins under the default jumper, with the event interrupt
		wr(OFS_IMSK, 8'h01);
		cmd(8'h4C);
		pins(8'h10, 4'h0);
		rd(OFS_PEND, 8'hE8, 1'b0);
		outs(1'b0, 1'b0);
		pins(8'h10, 4'h1);
		rd(OFS_PEND, 8'hF8, 1'b0);
		outs(1'b1, 1'b0);
		wr(OFS_ISTS, 8'h01);
		outs(1'b0, 1'b0);
		wr(OFS_IMSK, 8'h00);
		pins(8'h11, 4'h1);
		rd(OFS_PEND, 8'hF9, 1'b0);
		rd(OFS_ISTS, 8'h01, 1'b0);
		outs(1'b0, 1'b1);
		// jumper out: all eight high port a lines are sources, replies are ignored
		cmd(8'h4F);
		cmd(8'h4E);
		@(posedge clk_sys);
		request_source_jumper <= 1'b0;
		pins(8'h91, 4'hF);
		rd(OFS_PEND, 8'hB9, 1'b0);
		outs(1'b0, 1'b1);
		repeat (3) @(posedge clk_sys);
		summarize();
	end
endmodule
`default_nettype wire
